// file: rtl/cdt_decode.sv
`timescale 1ns/1ps

module cdt_decode (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        ins_valid,
    input  wire logic [17:0] ins_word,
    input  wire logic [15:0] ins_ext,
    input  wire logic [3:0]  cond_flags,
    input  wire logic        mem_ack,
    input  wire logic [15:0] mem_rdata,
    output logic             ins_ready,
    output logic             op_done,
    output logic             op_undef,
    output logic      [2:0]  op_class,
    output logic      [5:0]  op_type,
    output logic             branch_taken,
    output logic             mem_req,
    output logic             mem_we,
    output logic             mem_word,
    output logic      [15:0] mem_addr,
    output logic      [15:0] mem_wdata,
    output logic             gpr_wr_en,
    output logic      [2:0]  gpr_wr_idx,
    output logic             gpr_wr_hi,
    output logic             gpr_wr_lo,
    output logic      [15:0] gpr_wr_data
);

    cdt_pkg::cdt_state_e state_reg;
    logic [17:0]         ins_reg;
    logic [15:0]         ext_reg;
    logic [15:0]         rd_a;
    logic [15:0]         rd_b;
    logic [15:0]         ptr_new_reg;
    logic [15:0]         load_reg;

    // ************************************************************
    // field extraction and stack aliasing
    // ************************************************************
    logic [5:0]  typ;
    logic [2:0]  cls;
    logic        is_push;
    logic        is_pop;
    logic        is_copy;
    logic [2:0]  e_mode;
    logic        e_store;
    logic        e_word;
    logic        e_low;
    logic [2:0]  e_rn;
    logic [2:0]  e_rm;
    logic        bad;
    logic        uses_mem;
    logic        adjusts;
    logic [15:0] step;
    logic [15:0] ea;
    logic [15:0] src_data;
    logic        cond_ok;

    assign typ     = ins_reg[cdt_pkg::TYPE_LSB +: cdt_pkg::TYPE_W];
    assign is_push = (typ == cdt_pkg::T_PUSH);
    assign is_pop  = (typ == cdt_pkg::T_POP);
    assign is_copy = (typ == cdt_pkg::T_DATA_COPY) || is_push || is_pop;
    assign e_mode  = is_push ? cdt_pkg::M_PREDEC :
                     is_pop  ? cdt_pkg::M_POSTINC :
                     ins_reg[cdt_pkg::MODE_LSB +: cdt_pkg::MODE_W];
    assign e_store = is_push ? 1'b1 : is_pop ? 1'b0 : ins_reg[cdt_pkg::STORE_BIT];
    assign e_word  = (is_push || is_pop) ? 1'b1 : ins_reg[cdt_pkg::WORD_BIT];
    assign e_low   = ins_reg[cdt_pkg::LOW_BIT];
    assign e_rn    = ins_reg[cdt_pkg::RN_LSB +: cdt_pkg::REG_IDX_W];
    assign e_rm    = (is_push || is_pop) ? cdt_pkg::STACK_REG_IDX
                                         : ins_reg[cdt_pkg::RM_LSB +: cdt_pkg::REG_IDX_W];

    // ************************************************************
    // class lookup
    // ************************************************************
    always_comb begin
        if (typ <= cdt_pkg::T_PERIPH_READ || is_push || is_pop) begin
            cls = cdt_pkg::C_TRANSFER;
        end else if (typ <= cdt_pkg::T_ARITH_LAST) begin
            cls = cdt_pkg::C_ARITH;
        end else if (typ <= cdt_pkg::T_LOGIC_LAST) begin
            cls = cdt_pkg::C_LOGIC;
        end else if (typ <= cdt_pkg::T_SHIFT_LAST) begin
            cls = cdt_pkg::C_SHIFT;
        end else if (typ <= cdt_pkg::T_BIT_LAST) begin
            cls = cdt_pkg::C_BIT;
        end else if (typ <= cdt_pkg::T_BRANCH_LAST) begin
            cls = cdt_pkg::C_BRANCH;
        end else if (typ <= cdt_pkg::T_SYS_LAST) begin
            cls = cdt_pkg::C_SYSTEM;
        end else begin
            cls = cdt_pkg::C_BLOCK;
        end
    end

    // ************************************************************
    // legality of the copy forms
    // ************************************************************
    always_comb begin
        bad = 1'b0;
        if (typ > cdt_pkg::T_POP) begin
            bad = 1'b1;
        end else if (typ == cdt_pkg::T_PERIPH_WRITE || typ == cdt_pkg::T_PERIPH_READ) begin
            bad = 1'b1;
        end else if (is_copy) begin
            case (e_mode)
                cdt_pkg::M_IMM:      bad = e_store;
                cdt_pkg::M_PREDEC:   bad = !e_store;
                cdt_pkg::M_POSTINC:  bad = e_store;
                cdt_pkg::M_SHORTABS: bad = e_word;
                default:             bad = 1'b0;
            endcase
        end
    end

    assign uses_mem = is_copy && (e_mode != cdt_pkg::M_REG) && (e_mode != cdt_pkg::M_IMM);
    assign adjusts  = (e_mode == cdt_pkg::M_PREDEC) || (e_mode == cdt_pkg::M_POSTINC);
    assign step     = e_word ? cdt_pkg::WORD_STEP : cdt_pkg::BYTE_STEP;

    // ************************************************************
    // effective address
    // ************************************************************
    always_comb begin
        case (e_mode)
            cdt_pkg::M_DISP16:   ea = rd_b + ext_reg;
            cdt_pkg::M_ABS16:    ea = ext_reg;
            cdt_pkg::M_PREDEC:   ea = rd_b - step;
            cdt_pkg::M_SHORTABS: ea = {cdt_pkg::SHORT_ABS_PAGE, ext_reg[7:0]};
            default:             ea = rd_b;
        endcase
    end

    // store source: word, or the selected half in the low lane
    assign src_data = e_word ? rd_a : {8'h00, (e_low ? rd_a[7:0] : rd_a[15:8])};

    // ************************************************************
    // branch condition
    // ************************************************************
    logic fn;
    logic fz;
    logic fv;
    logic fc;
    assign {fn, fz, fv, fc} = cond_flags;

    always_comb begin
        case (ins_reg[cdt_pkg::CC_LSB +: cdt_pkg::CC_W])
            cdt_pkg::CC_ALWAYS: cond_ok = 1'b1;
            cdt_pkg::CC_NEVER:  cond_ok = 1'b0;
            cdt_pkg::CC_HI:     cond_ok = !(fc || fz);
            cdt_pkg::CC_LS:     cond_ok = fc || fz;
            cdt_pkg::CC_CC:     cond_ok = !fc;
            cdt_pkg::CC_CS:     cond_ok = fc;
            cdt_pkg::CC_NE:     cond_ok = !fz;
            cdt_pkg::CC_EQ:     cond_ok = fz;
            cdt_pkg::CC_VC:     cond_ok = !fv;
            cdt_pkg::CC_VS:     cond_ok = fv;
            cdt_pkg::CC_PL:     cond_ok = !fn;
            cdt_pkg::CC_MI:     cond_ok = fn;
            cdt_pkg::CC_GE:     cond_ok = !(fn ^ fv);
            cdt_pkg::CC_LT:     cond_ok = fn ^ fv;
            cdt_pkg::CC_GT:     cond_ok = !(fz || (fn ^ fv));
            default:            cond_ok = fz || (fn ^ fv);
        endcase
    end

    // ************************************************************
    // register file
    // ************************************************************
    cdt_gpr u_gpr (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .wr_en     (gpr_wr_en),
        .wr_idx    (gpr_wr_idx),
        .wr_hi     (gpr_wr_hi),
        .wr_lo     (gpr_wr_lo),
        .wr_data   (gpr_wr_data),
        .rd_idx_a  (e_rn),
        .rd_idx_b  (e_rm),
        .rd_data_a (rd_a),
        .rd_data_b (rd_b)
    );

    // ************************************************************
    // sequencing
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= cdt_pkg::ST_IDLE;
            ins_ready <= 1'b1;
        end else begin
            case (state_reg)
                cdt_pkg::ST_IDLE: begin
                    if (ins_valid) begin
                        state_reg <= cdt_pkg::ST_READ;
                        ins_ready <= 1'b0;
                    end
                end
                cdt_pkg::ST_READ: begin
                    state_reg <= cdt_pkg::ST_EXEC;
                end
                cdt_pkg::ST_EXEC: begin
                    if (!bad && uses_mem) begin
                        state_reg <= cdt_pkg::ST_MEM;
                    end else begin
                        state_reg <= cdt_pkg::ST_IDLE;
                        ins_ready <= 1'b1;
                    end
                end
                cdt_pkg::ST_MEM: begin
                    if (mem_ack && !e_store) begin
                        state_reg <= cdt_pkg::ST_WB;
                    end else if (mem_ack) begin
                        state_reg <= cdt_pkg::ST_IDLE;
                        ins_ready <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= cdt_pkg::ST_IDLE;
                    ins_ready <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ins_reg <= 18'h00000;
            ext_reg <= 16'h0000;
        end else if (state_reg == cdt_pkg::ST_IDLE && ins_valid) begin
            ins_reg <= ins_word;
            ext_reg <= ins_ext;
        end
    end

    // ************************************************************
    // status outputs
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            op_done      <= 1'b0;
            op_undef     <= 1'b0;
            op_class     <= 3'h0;
            op_type      <= 6'h00;
            branch_taken <= 1'b0;
        end else begin
            op_done      <= 1'b0;
            op_undef     <= 1'b0;
            branch_taken <= 1'b0;
            if (state_reg == cdt_pkg::ST_EXEC) begin
                op_class <= cls;
                op_type  <= typ;
                op_undef <= bad;
                op_done  <= bad || !uses_mem;
                branch_taken <= !bad && typ == cdt_pkg::T_BRANCH_COND && cond_ok;
            end else if (state_reg == cdt_pkg::ST_MEM) begin
                op_done <= mem_ack && e_store;
            end else if (state_reg == cdt_pkg::ST_WB) begin
                op_done <= 1'b1;
            end
        end
    end

    // ************************************************************
    // memory bus
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_req     <= 1'b0;
            mem_we      <= 1'b0;
            mem_word    <= 1'b0;
            mem_addr    <= 16'h0000;
            mem_wdata   <= 16'h0000;
            ptr_new_reg <= 16'h0000;
            load_reg    <= 16'h0000;
        end else begin
            if (state_reg == cdt_pkg::ST_EXEC && !bad && uses_mem) begin
                mem_req  <= 1'b1;
                mem_we   <= e_store;
                mem_word <= e_word;
                // odd word address silently rounds down, no fault
                mem_addr <= e_word ? {ea[15:1], 1'b0} : ea;
                mem_wdata   <= e_store ? src_data : 16'h0000;
                ptr_new_reg <= (e_mode == cdt_pkg::M_PREDEC) ? rd_b - step : rd_b + step;
            end else if (state_reg == cdt_pkg::ST_MEM && mem_ack) begin
                mem_req  <= 1'b0;
                mem_we   <= 1'b0;
                load_reg <= mem_rdata;
            end
        end
    end

    // ************************************************************
    // register write-back
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            gpr_wr_en   <= 1'b0;
            gpr_wr_idx  <= 3'h0;
            gpr_wr_hi   <= 1'b0;
            gpr_wr_lo   <= 1'b0;
            gpr_wr_data <= 16'h0000;
        end else begin
            gpr_wr_en <= 1'b0;
            if (state_reg == cdt_pkg::ST_EXEC && !bad && is_copy && !uses_mem) begin
                gpr_wr_en   <= 1'b1;
                gpr_wr_idx  <= e_rn;
                gpr_wr_hi   <= e_word || !e_low;
                gpr_wr_lo   <= e_word || e_low;
                if (e_mode == cdt_pkg::M_IMM) begin
                    gpr_wr_data <= e_word ? ext_reg : {ext_reg[7:0], ext_reg[7:0]};
                end else begin
                    gpr_wr_data <= e_word ? rd_b : {2{(e_low ? rd_b[7:0] : rd_b[15:8])}};
                end
            end else if (state_reg == cdt_pkg::ST_MEM && mem_ack && adjusts) begin
                // pointer first so a load into the same register wins
                gpr_wr_en   <= 1'b1;
                gpr_wr_idx  <= e_rm;
                gpr_wr_hi   <= 1'b1;
                gpr_wr_lo   <= 1'b1;
                gpr_wr_data <= ptr_new_reg;
            end else if (state_reg == cdt_pkg::ST_WB) begin
                gpr_wr_en   <= 1'b1;
                gpr_wr_idx  <= e_rn;
                gpr_wr_hi   <= e_word || !e_low;
                gpr_wr_lo   <= e_word || e_low;
                gpr_wr_data <= e_word ? load_reg : {load_reg[7:0], load_reg[7:0]};
            end
        end
    end

endmodule

// file: rtl/cdt_pkg.sv
package cdt_pkg;

    // ************************************************************
    // instruction word from fetch
    // ************************************************************
    localparam int INS_W       = 18;
    localparam int EXT_W       = 16;
    localparam int TYPE_LSB    = 12;
    localparam int TYPE_W      = 6;
    localparam int STORE_BIT   = 11;
    localparam int MODE_LSB    = 8;
    localparam int MODE_W      = 3;
    localparam int WORD_BIT    = 7;
    localparam int LOW_BIT     = 6;
    localparam int RN_LSB      = 3;
    localparam int RM_LSB      = 0;
    localparam int REG_IDX_W   = 3;
    localparam int CC_LSB      = 0;
    localparam int CC_W        = 4;

    // ************************************************************
    // instruction type codes, grouped by class
    // ************************************************************
    localparam int NUM_TYPES = 57;
    localparam logic [5:0] T_DATA_COPY    = 6'h00;
    localparam logic [5:0] T_PERIPH_WRITE = 6'h01;
    localparam logic [5:0] T_PERIPH_READ  = 6'h02;
    localparam logic [5:0] T_ARITH_FIRST  = 6'h03;
    localparam logic [5:0] T_ARITH_LAST   = 6'h10;
    localparam logic [5:0] T_LOGIC_FIRST  = 6'h11;
    localparam logic [5:0] T_LOGIC_LAST   = 6'h14;
    localparam logic [5:0] T_SHIFT_FIRST  = 6'h15;
    localparam logic [5:0] T_SHIFT_LAST   = 6'h1c;
    localparam logic [5:0] T_BIT_FIRST    = 6'h1d;
    localparam logic [5:0] T_BIT_LAST     = 6'h2a;
    localparam logic [5:0] T_BRANCH_FIRST = 6'h2b;
    localparam logic [5:0] T_BRANCH_COND  = 6'h2b;
    localparam logic [5:0] T_BRANCH_LAST  = 6'h2f;
    localparam logic [5:0] T_SYS_FIRST    = 6'h30;
    localparam logic [5:0] T_SYS_LAST     = 6'h37;
    localparam logic [5:0] T_BLOCK        = 6'h38;
    // stack forms are aliases of the word copy
    localparam logic [5:0] T_PUSH         = 6'h39;
    localparam logic [5:0] T_POP          = 6'h3a;

    // ************************************************************
    // class codes
    // ************************************************************
    localparam logic [2:0] C_TRANSFER = 3'h0;
    localparam logic [2:0] C_ARITH    = 3'h1;
    localparam logic [2:0] C_LOGIC    = 3'h2;
    localparam logic [2:0] C_SHIFT    = 3'h3;
    localparam logic [2:0] C_BIT      = 3'h4;
    localparam logic [2:0] C_BRANCH   = 3'h5;
    localparam logic [2:0] C_SYSTEM   = 3'h6;
    localparam logic [2:0] C_BLOCK    = 3'h7;

    // ************************************************************
    // addressing modes of the data copy
    // ************************************************************
    localparam logic [2:0] M_REG      = 3'h0;
    localparam logic [2:0] M_INDIRECT = 3'h1;
    localparam logic [2:0] M_DISP16   = 3'h2;
    localparam logic [2:0] M_ABS16    = 3'h3;
    localparam logic [2:0] M_IMM      = 3'h4;
    localparam logic [2:0] M_PREDEC   = 3'h5;
    localparam logic [2:0] M_POSTINC  = 3'h6;
    localparam logic [2:0] M_SHORTABS = 3'h7;

    localparam logic [2:0]  STACK_REG_IDX  = 3'h7;
    localparam logic [15:0] BYTE_STEP      = 16'h0001;
    localparam logic [15:0] WORD_STEP      = 16'h0002;
    localparam logic [7:0]  SHORT_ABS_PAGE = 8'hff;

    // ************************************************************
    // branch conditions, flags are {n, z, v, c}
    // ************************************************************
    localparam logic [3:0] CC_ALWAYS = 4'h0;
    localparam logic [3:0] CC_NEVER  = 4'h1;
    localparam logic [3:0] CC_HI     = 4'h2;
    localparam logic [3:0] CC_LS     = 4'h3;
    localparam logic [3:0] CC_CC     = 4'h4;
    localparam logic [3:0] CC_CS     = 4'h5;
    localparam logic [3:0] CC_NE     = 4'h6;
    localparam logic [3:0] CC_EQ     = 4'h7;
    localparam logic [3:0] CC_VC     = 4'h8;
    localparam logic [3:0] CC_VS     = 4'h9;
    localparam logic [3:0] CC_PL     = 4'ha;
    localparam logic [3:0] CC_MI     = 4'hb;
    localparam logic [3:0] CC_GE     = 4'hc;
    localparam logic [3:0] CC_LT     = 4'hd;
    localparam logic [3:0] CC_GT     = 4'he;
    localparam logic [3:0] CC_LE     = 4'hf;

    typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_EXEC, ST_MEM, ST_WB} cdt_state_e;

endpackage

// file: rtl/cdt_gpr.sv
`timescale 1ns/1ps

// eight 16-bit registers, byte halves written separately, registered reads
module cdt_gpr (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_idx,
    input  wire logic        wr_hi,
    input  wire logic        wr_lo,
    input  wire logic [15:0] wr_data,
    input  wire logic [2:0]  rd_idx_a,
    input  wire logic [2:0]  rd_idx_b,
    output logic      [15:0] rd_data_a,
    output logic      [15:0] rd_data_b
);

    // contents are not initialised by reset, as on the real core
    logic [15:0] regs [0:7];

    always_ff @(posedge sys_clk) begin
        if (wr_en && wr_hi) begin
            regs[wr_idx][15:8] <= wr_data[15:8];
        end
        if (wr_en && wr_lo) begin
            regs[wr_idx][7:0] <= wr_data[7:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_a <= 16'h0000;
            rd_data_b <= 16'h0000;
        end else begin
            rd_data_a <= regs[rd_idx_a];
            rd_data_b <= regs[rd_idx_b];
        end
    end

endmodule

// file: tb/cdt_mem_model.sv
`timescale 1ns/1ps

// ****
// memory partner, ack after wait_cyc idle cycles
// ****
module cdt_mem_model (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    input  wire logic [1:0]  wait_cyc,
    output logic             mem_ack,
    output logic      [15:0] mem_rdata
);
    // low address byte picks the word: enough for the handful of addresses the bench uses
    logic [15:0]  mem [0:255];
    logic [255:0] used_reg;
    logic [1:0]   cnt_reg;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_ack <= 1'b0;
            cnt_reg <= 2'h0;
            mem_rdata <= 16'h0000;
            used_reg <= {256{1'b0}};
        end else begin
            mem_ack <= 1'b0;
            // stale read data flips so it is never mistaken for a fresh answer
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack && cnt_reg == wait_cyc) begin
                mem_ack <= 1'b1;
                cnt_reg <= 2'h0;
                if (mem_we) begin
                    mem[mem_addr[7:0]]      <= mem_wdata;
                    used_reg[mem_addr[7:0]] <= 1'b1;
                end else begin
                    mem_rdata <= used_reg[mem_addr[7:0]] ? mem[mem_addr[7:0]] : 16'hdead;
                end
            end else if (mem_req && !mem_ack) begin
                cnt_reg <= cnt_reg + 2'h1;
            end
        end
    end
endmodule

// file: tb/cdt_decode_chk.sv
`timescale 1ns/1ps

// ****
// port checker
// ****
module cdt_decode_chk (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        ins_valid,
    input wire logic [17:0] ins_word,
    input wire logic        ins_ready,
    input wire logic        op_done,
    input wire logic        op_undef,
    input wire logic [2:0]  op_class,
    input wire logic        branch_taken,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic        mem_word,
    input wire logic        mem_ack,
    input wire logic [15:0] mem_addr,
    input wire logic        gpr_wr_en
);
    wire       acc = ins_valid && ins_ready;
    wire [5:0] ty  = ins_word[17:12];

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_word_even: assert property (mem_req && mem_word |-> !mem_addr[0]) else $error("odd word address");
    a_undef_quiet: assert property (op_undef |-> op_done && !gpr_wr_en && !mem_req) else $error("undef updated");
    a_periph_undef: assert property (acc && ty inside {6'h01, 6'h02} |-> ##3 op_done && op_undef)
        else $error("peripheral transfer accepted");
    a_short_word: assert property (acc && ty == 6'h00 && ins_word[10:7] == 4'hf |-> ##3 op_undef)
        else $error("word short absolute accepted");
    a_arith_class: assert property (acc && ty inside {[6'h03:6'h10]} |-> ##3 op_class == 3'h1)
        else $error("arith class wrong");
    a_shift_class: assert property (acc && ty inside {[6'h15:6'h1c]} |-> ##3 op_class == 3'h3)
        else $error("shift class wrong");
    a_push_store: assert property (acc && ty == 6'h39 |-> ##3 mem_req && mem_we && mem_word)
        else $error("push not a word store");
    a_pop_load: assert property (acc && ty == 6'h3a |-> ##3 mem_req && !mem_we && mem_word)
        else $error("pop not a word load");
    a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)) else $error("request dropped");

    c_push: cover property (acc && ty == 6'h39);
    c_pop: cover property (acc && ty == 6'h3a);
    c_taken: cover property (branch_taken);
endmodule

bind cdt_decode cdt_decode_chk u_chk (.*);

// file: tb/test_cpu_data_transfer_decode.sv
`timescale 1ns/1ps

// ****
// stimulus and checks
// ****
module test_cpu_data_transfer_decode;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        ins_valid = 1'b0;
    logic [17:0] ins_word = 18'h00000;
    logic [15:0] ins_ext = 16'h0000;
    logic [3:0]  cond_flags = 4'h0;
    logic [1:0]  wait_cyc = 2'h0;
    logic        mem_ack, ins_ready, op_done, op_undef, branch_taken, mem_req, mem_we, mem_word;
    logic        gpr_wr_en, gpr_wr_hi, gpr_wr_lo, d_undef, d_taken;
    logic [1:0]  w_lane;
    logic [2:0]  op_class, gpr_wr_idx, w_idx, d_class;
    logic [5:0]  op_type, d_type;
    logic [15:0] mem_rdata, mem_addr, mem_wdata, gpr_wr_data, w_data, m_addr, m_data;
    int          bad_count = 0, compares = 0, w_cnt = 0, m_cnt = 0, i;
    // {type, class}: first and last code of each class from arith to system (branch from 2c), plus block and push
    logic [8:0]  rows [14] = '{{6'h03, 3'h1}, {6'h10, 3'h1}, {6'h11, 3'h2}, {6'h14, 3'h2}, {6'h15, 3'h3},
        {6'h1c, 3'h3}, {6'h1d, 3'h4}, {6'h2a, 3'h4}, {6'h2c, 3'h5}, {6'h2f, 3'h5}, {6'h30, 3'h6},
        {6'h37, 3'h6}, {6'h38, 3'h7}, {6'h39, 3'h0}};
    logic [17:0] undefs [6] = '{18'h01000, 18'h02000, 18'h00780, 18'h00c00, 18'h00500, 18'h3b000};

    always #2 sys_clk = ~sys_clk;

    cdt_decode dut (.*);
    cdt_mem_model u_mem (.*);

    always @(posedge sys_clk) begin
        if (gpr_wr_en === 1'b1) begin
            {w_idx, w_lane, w_data} <= {gpr_wr_idx, gpr_wr_hi, gpr_wr_lo, gpr_wr_data};
            w_cnt++;
        end
        if (mem_req === 1'b1 && mem_ack === 1'b1) begin
            {m_addr, m_data} <= {mem_addr, mem_wdata};
            m_cnt++;
        end
    end

    task chk(input logic [39:0] got, input logic [39:0] exp);
        compares++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask

    task stop_test(input bit t);
        bad_count += t;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    function automatic logic [17:0] mk(logic [5:0] t, logic s, logic [2:0] m, logic w, logic lo, logic [5:0] r);
        return {t, s, m, w, lo, r};
    endfunction

    task run(input logic [17:0] w, input logic [15:0] e);
        @(posedge sys_clk);
        ins_valid <= 1'b1;
        ins_word <= w;
        ins_ext <= e;
        @(posedge sys_clk);
        ins_valid <= 1'b0;
        for (i = 0; i < 40 && op_done !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (i == 40)
            stop_test(1'b1);
        {d_undef, d_taken, d_class, d_type} = {op_undef, branch_taken, op_class, op_type};
        @(posedge sys_clk);
        #1;
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        chk({ins_ready, op_done, mem_req, gpr_wr_en}, 4'h8);
        rst_b <= 1'b1;
        run(mk(6'h00, 1'b0, 3'h4, 1'b1, 1'b0, 6'h00), 16'h1234);
        chk({w_idx, w_data}, {3'h0, 16'h1234});
        run(mk(6'h00, 1'b0, 3'h4, 1'b1, 1'b0, 6'h38), 16'h0200);
        run(mk(6'h00, 1'b0, 3'h4, 1'b1, 1'b0, 6'h08), 16'h2001);
        foreach (rows[k]) begin
            run(mk(rows[k][8:3], 1'b0, 3'h0, 1'b0, 1'b0, 6'h00), 16'h0000);
            chk({d_undef, d_class, d_type}, {1'b0, rows[k][2:0], rows[k][8:3]});
        end
        run(mk(6'h00, 1'b0, 3'h0, 1'b1, 1'b0, 6'h18), 16'h0000);
        chk({w_idx, w_data}, {3'h3, 16'h1234});
        // slow memory on the stack pair; the push row above already moved the pointer to 01fe
        wait_cyc <= 2'h2;
        run(mk(6'h39, 1'b1, 3'h5, 1'b1, 1'b0, 6'h07), 16'h0000);
        chk({m_addr, m_data, w_idx, w_data}, {16'h01fc, 16'h1234, 3'h7, 16'h01fc});
        run(mk(6'h3a, 1'b0, 3'h6, 1'b1, 1'b0, 6'h27), 16'h0000);
        chk({m_addr, w_idx, w_data}, {16'h01fc, 3'h4, 16'h1234});
        chk(w_cnt[15:0], 16'h0008);
        wait_cyc <= 2'h0;
        run(mk(6'h00, 1'b1, 3'h1, 1'b1, 1'b0, 6'h01), 16'h0000);
        chk(m_addr, 16'h2000);
        run(mk(6'h00, 1'b1, 3'h5, 1'b0, 1'b1, 6'h01), 16'h0000);
        chk({m_addr, m_data, w_data}, {16'h2000, 16'h0034, 16'h2000});
        run(mk(6'h00, 1'b0, 3'h7, 1'b0, 1'b1, 6'h28), 16'h0010);
        chk({m_addr, w_idx, w_lane}, {16'hff10, 3'h5, 2'h1});
        foreach (undefs[k]) begin
            run(undefs[k], 16'h0000);
            chk({d_undef, w_cnt[15:0], m_cnt[15:0]}, {1'b1, 16'h000a, 16'h0006});
        end
        for (int j = 0; j < 2; j++) begin
            cond_flags <= {1'b0, j[0], 2'h0};
            run(mk(6'h2b, 1'b0, 3'h0, 1'b0, 1'b0, 6'h07), 16'h0000);
            chk(d_taken, j[0]);
        end
        // reset lands while a push waits on memory
        wait_cyc <= 2'h3;
        @(posedge sys_clk);
        ins_valid <= 1'b1;
        ins_word <= mk(6'h39, 1'b1, 3'h5, 1'b1, 1'b0, 6'h07);
        @(posedge sys_clk);
        ins_valid <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b0;
        #1;
        chk({ins_ready, op_done, mem_req, gpr_wr_en}, 4'h8);
        @(posedge sys_clk);
        rst_b <= 1'b1;
        // register contents survive reset, so a copy of r0 still gives its old value
        run(mk(6'h00, 1'b0, 3'h0, 1'b1, 1'b0, 6'h20), 16'h0000);
        chk({d_undef, w_idx, w_data}, {1'b0, 3'h4, 16'h1234});
        stop_test(1'b0);
    end
endmodule
